// ===== logic/rro_exec.sv
// Executor for software reset and the three return instructions.
// Assumes one i_valid pulse per instruction cycle from the decode stage
// and a return stack that pops in the cycle o_stack_pop is high.
`timescale 1ns/1ps
// Notes on behaviour
// - Software reset instruction requests a full device reset.
// - Software reset clears the reset instruction indicator bit.
// - Return from interrupt pops the stack and loads the PC.
// - Return from interrupt sets global interrupt enable, bit 7.
// - Return from interrupt is one word and two cycles.
// - Return pops the stack into the PC, nothing else changes.
// - Return takes two instruction cycles.
// - Literal return loads the working register with its 8-bit literal.
// - Literal return loads the PC from top of return stack.
// - Literal return is one word and two cycles.
module rro_exec (
    input  wire logic        i_clk,               // core clock
    input  wire logic        i_srst,              // sync reset, high
    input  wire logic        i_valid,             // instruction cycle pulse
    input  wire logic [13:0] i_instr,             // instruction word
    input  wire logic [14:0] i_top_of_return_stack, // stack top value
    output logic             o_busy,              // second cycle running
    output logic             o_stack_pop,         // pop stack, pulse
    output logic             o_pc_load,           // load PC, pulse
    output logic [14:0]      o_pc_value,          // new PC value
    output logic             o_w_load,            // load W, pulse
    output logic [7:0]       o_w_value,           // new W value
    output logic             o_gie_set,           // set enable, pulse
    output logic [7:0]       o_interrupt_control_register_set_mask,   // bits to set
    output logic             o_soft_reset,        // device reset, pulse
    output logic             o_ri_clear,          // clear indicator
    output logic             o_status_we          // status write, always 0
);
    rro_pkg::rro_op_type op;
    logic [7:0]          lit;
    logic [1:0]          cyc_q;
    logic                start;

    rro_decode u_dec (
        .i_instr (i_instr),
        .o_op    (op),
        .o_lit   (lit)
    );

    // The first cycle of a two-cycle operation is taken; the second is idle.
    assign start  = i_valid && (cyc_q == '0);
    assign o_busy = (cyc_q != '0);

    always_ff @(posedge i_clk)
    begin
        if (i_srst)
            cyc_q <= '0;
        else if (i_valid && cyc_q != '0)
            cyc_q <= cyc_q - 2'h1;
        else if (start && (op == rro_pkg::RRO_OP_RETFI ||
                 op == rro_pkg::RRO_OP_RETURN ||
                 op == rro_pkg::RRO_OP_RETURN_WITH_LITERAL_OP))
            cyc_q <= rro_pkg::RET_CYCLES - 2'h1;
    end

    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            o_stack_pop <= 1'b0;
            o_pc_load   <= 1'b0;
            o_pc_value  <= '0;
        end
        else
        begin
            o_stack_pop <= start && (op == rro_pkg::RRO_OP_RETFI ||
                           op == rro_pkg::RRO_OP_RETURN ||
                           op == rro_pkg::RRO_OP_RETURN_WITH_LITERAL_OP);
            o_pc_load   <= start && (op == rro_pkg::RRO_OP_RETFI ||
                           op == rro_pkg::RRO_OP_RETURN ||
                           op == rro_pkg::RRO_OP_RETURN_WITH_LITERAL_OP);
            if (start)
                o_pc_value <= i_top_of_return_stack;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            o_w_load  <= 1'b0;
            o_w_value <= '0;
        end
        else
        begin
            o_w_load <= start && op == rro_pkg::RRO_OP_RETURN_WITH_LITERAL_OP;
            if (start && op == rro_pkg::RRO_OP_RETURN_WITH_LITERAL_OP)
                o_w_value <= lit;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_srst)
            o_gie_set <= 1'b0;
        else
            o_gie_set <= start && op == rro_pkg::RRO_OP_RETFI;
    end
    assign o_interrupt_control_register_set_mask = o_gie_set ?
        8'(1 << rro_pkg::GIE_BIT) : 8'h00;

    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            o_soft_reset <= 1'b0;
            o_ri_clear   <= 1'b0;
        end
        else
        begin
            o_soft_reset <= start && op == rro_pkg::RRO_OP_RESET;
            o_ri_clear   <= start && op == rro_pkg::RRO_OP_RESET;
        end
    end

    assign o_status_we = 1'b0;
endmodule

// ===== logic/rro_pkg.sv
// Package for the return and reset instruction executor.
// Assumes a 14-bit instruction word and a 15-bit program counter.
package rro_pkg;
    localparam int unsigned INSTR_W    = 14;
    localparam int unsigned PC_W       = 15;
    localparam int unsigned DATA_W     = 8;
    localparam int unsigned INTERRUPT_CONTROL_REGISTER_W   = 8;
    localparam int unsigned GIE_BIT    = 7;
    localparam int unsigned CYC_CNT_W  = 2;
    // Each of the three return operations takes two instruction cycles.
    localparam logic [1:0]  RET_CYCLES = 2'h2;
    localparam logic [13:0] OP_RESET   = 14'h0001;
    localparam logic [13:0] OP_RETFI   = 14'h0009;
    localparam logic [13:0] OP_RETURN  = 14'h0008;
    localparam logic [13:0] OP_RETURN_WITH_LITERAL_OP_M = 14'h3f00;
    localparam logic [13:0] OP_RETURN_WITH_LITERAL_OP_V = 14'h3400;
    localparam logic [13:0] LIT_MASK   = 14'h00ff;

    typedef enum logic [2:0] {
        RRO_OP_NONE,
        RRO_OP_RESET,
        RRO_OP_RETFI,
        RRO_OP_RETURN,
        RRO_OP_RETURN_WITH_LITERAL_OP
    } rro_op_type;
endpackage

// ===== logic/rro_decode.sv
// Classifies one instruction word for the return/reset executor.
// Assumes a valid word from the core's fetch stage.
`timescale 1ns/1ps
module rro_decode (
    input  wire logic [13:0]       i_instr,  // instruction word
    output rro_pkg::rro_op_type    o_op,     // decoded operation
    output logic [7:0]             o_lit     // literal field
);
    always_comb
    begin
        o_lit = i_instr[rro_pkg::DATA_W-1:0];
        if (i_instr == rro_pkg::OP_RESET)
            o_op = rro_pkg::RRO_OP_RESET;
        else if (i_instr == rro_pkg::OP_RETFI)
            o_op = rro_pkg::RRO_OP_RETFI;
        else if (i_instr == rro_pkg::OP_RETURN)
            o_op = rro_pkg::RRO_OP_RETURN;
        else if ((i_instr & rro_pkg::OP_RETURN_WITH_LITERAL_OP_M) == rro_pkg::OP_RETURN_WITH_LITERAL_OP_V)
            o_op = rro_pkg::RRO_OP_RETURN_WITH_LITERAL_OP;
        else
            o_op = rro_pkg::RRO_OP_NONE;
    end
endmodule

// ===== verif/rro_exec_props.sv
// Checker for the return and reset executor.
// Assumes it sees only the ports of rro_exec.
`timescale 1ns/1ps
module rro_exec_props (
    input wire logic i_clk, i_srst, i_valid, o_busy, o_stack_pop, o_pc_load,
    input wire logic o_w_load, o_gie_set, o_soft_reset, o_ri_clear,
    input wire logic o_status_we,
    input wire logic [13:0] i_instr,
    input wire logic [14:0] i_top_of_return_stack, o_pc_value,
    input wire logic [7:0] o_w_value, o_interrupt_control_register_set_mask
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_srst);
    sequence s_op(logic [13:0] op);
        i_valid && !o_busy && i_instr == op;
    endsequence
    sequence s_lit;
        i_valid && !o_busy && i_instr[13:8] == 6'h34;
    endsequence
    AST_RESET: assert property (s_op(rro_pkg::OP_RESET) |=>
        o_soft_reset && o_ri_clear) else $error("no reset");
    AST_POP: assert property (o_pc_load |-> o_stack_pop &&
        o_pc_value == $past(i_top_of_return_stack)) else $error("bad pop");
    AST_ENABLE: assert property (s_op(rro_pkg::OP_RETFI) |=>
        o_gie_set && o_interrupt_control_register_set_mask == 8'h80) else $error("no enable");
    AST_BUSY: assert property (o_stack_pop |-> o_busy)
        else $error("pop not busy");
    AST_SECOND: assert property (o_busy && i_valid |=> !o_busy &&
        !o_stack_pop && !o_soft_reset) else $error("second acted");
    AST_RETURN: assert property (s_op(rro_pkg::OP_RETURN) |=>
        o_pc_load && !o_w_load && !o_gie_set) else $error("bad return");
    AST_LIT: assert property (s_lit |=> o_w_load && o_pc_load &&
        {6'h34, o_w_value} == $past(i_instr)) else $error("bad literal");
    AST_STATUS: assert property (!o_status_we) else $error("flags");
endmodule
bind rro_exec rro_exec_props props_u (.*);

// ===== verif/tb_top.sv
// Self-checking bench for the return and reset executor.
// Assumes a 100 MHz clock and a synchronous active-high reset.
`timescale 1ns/1ps
module tb_top;
    logic i_clk = 0, i_srst = 1, i_valid = 0, o_busy, o_stack_pop, o_pc_load;
    logic o_w_load, o_gie_set, o_soft_reset, o_ri_clear, o_status_we;
    logic [13:0] i_instr = 0;
    logic [14:0] i_top_of_return_stack = 0, o_pc_value;
    logic [7:0] o_w_value, o_interrupt_control_register_set_mask, k;
    logic [29:0] exp_q[$];
    logic [31:0] r = 32'h132c;
    int err_total = 0, comparisons = 0, cyc = 0;
    wire [29:0] got = {o_soft_reset, o_ri_clear, o_gie_set,
        o_interrupt_control_register_set_mask[7], o_stack_pop, o_pc_load, o_w_load,
        o_w_load ? o_w_value : 8'h0, o_pc_load ? o_pc_value : 15'h0};
    rro_exec dut_u (.*);
    function automatic logic [31:0] nx(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic wrap_up(int late);
        err_total += late;
        $display("comparisons %0d errors %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(logic [29:0] e);
        comparisons++;
        err_total += int'(got !== e);
        if (got !== e)
            $display("unexpected at %0t: %h", $time, got);
    endtask
    // The second word of a return is random and must be ignored.
    task automatic issue(logic [13:0] ins, logic [6:0] f, bit two);
        i_valid = 1;
        i_instr = ins;
        i_top_of_return_stack = r[14:0];
        if (f != 0)
            exp_q.push_back({f, f[0] ? k : 8'h0, f[1] ? r[14:0] : 15'h0});
        @(negedge i_clk);
        if (two)
            i_instr = r[31:18];
        repeat (two) @(negedge i_clk);
    endtask
    initial
        forever #5 i_clk = ~i_clk;
    always @(posedge i_clk)
        if (++cyc == 2000)
            wrap_up(1);
    always @(negedge i_clk)
        if (!i_srst && got[29:23] != 0)
            chk(exp_q.size() ? exp_q.pop_front() : 30'h0);
    initial
    begin
        repeat (10) @(negedge i_clk);
        i_srst = 0;
        for (int i = 0; i < 15; i++)
        begin
            r = nx(r);
            k = i == 3 ? 8'h0 : i == 8 ? 8'hff : r[7:0];
            case (i % 5)
                0: issue(rro_pkg::OP_RESET, 7'h60, 0);
                1: issue(rro_pkg::OP_RETFI, 7'h1e, 1);
                2: issue(rro_pkg::OP_RETURN, 7'h06, 1);
                3: issue({6'h34, k}, 7'h07, 1);
                default: issue(14'h0, 7'h0, 0);
            endcase
            $display("test %0d done", i);
        end
        i_valid = 0;
        repeat (3) @(negedge i_clk);
        chk(exp_q.size() ? exp_q[0] : 30'h0);
        wrap_up(0);
    end
endmodule
